// ---- dio_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the discrete diagnostics block.
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH
`define DIO_IN_PTS 16
`define DIO_OUT_PTS 8
`define DIO_PORTS 2
`define DIO_AW 5
`define DIO_DW 32
// Register offsets (word addresses).
`define DIO_A_IN_OW_EN 5'h00
`define DIO_A_IN_SC_EN 5'h01
`define DIO_A_IN_COS_MASK 5'h02
`define DIO_A_CTRL 5'h03
`define DIO_A_IN_THR 5'h04
`define DIO_A_OUT_NL_EN 5'h05
`define DIO_A_OUT_DATA 5'h06
`define DIO_A_RPI 5'h07
`define DIO_A_CMD 5'h08
`define DIO_A_IN_STAT 5'h09
`define DIO_A_IN_FAULT 5'h0a
`define DIO_A_OUT_FAULT 5'h0b
`define DIO_A_RED_STAT 5'h0c
`define DIO_A_LINK_STAT 5'h0d
`define DIO_A_IRQ_STAT 5'h0e
`define DIO_A_IRQ_MASK 5'h0f
// Control register fields.
`define DIO_CTRL_IN_LATCH 0
`define DIO_CTRL_OUT_LATCH 1
`define DIO_CTRL_DIAG_COS 2
`define DIO_CTRL_DUPLEX 3
// Command register fields (write one to act).
`define DIO_CMD_IN_RESET 0
`define DIO_CMD_OUT_RESET 1
`define DIO_CMD_SHORT_RESET 2
`define DIO_CMD_TAG_RESET 3
// Threshold field widths and reset values.
`define DIO_THR_W 8
`define DIO_THR_ACT_RST 8'h80
`define DIO_THR_SC_RST 8'he0
`define DIO_THR_OW_RST 8'h10
`define DIO_RPI_RST 16'h0fa0
// Interrupt status bits.
`define DIO_IRQ_IN_PROD 0
`define DIO_IRQ_OUT_PROD 1
`define DIO_IRQ_IN_FAULT 2
`define DIO_IRQ_OUT_FAULT 3
`define DIO_IRQ_W 4
// Packet interval unit: 1 ms at 40 MHz.
`define DIO_CLK_HZ 40000000
`define DIO_TICK_US 1000
`define DIO_TICK_CYC ((`DIO_CLK_HZ / 1000000) * `DIO_TICK_US)
`endif

// ---- dio_pkg.sv ----
// Types shared by the discrete diagnostics block.
`default_nettype none
package dio_pkg;
   `include "dio_cfg.svh"
   typedef logic [`DIO_IN_PTS-1:0] dio_in_t;
   typedef logic [`DIO_OUT_PTS-1:0] dio_out_t;
   typedef logic [`DIO_THR_W-1:0] dio_thr_t;
   typedef logic [`DIO_AW-1:0] dio_addr_t;
   typedef logic [`DIO_DW-1:0] dio_data_t;
endpackage : dio_pkg
`default_nettype wire

// ---- dio_diag.sv ----
// Diagnostic and data-production logic for a discrete input and a discrete output module.
//
// Function
// - Input COS trigger per point, diagnostics module-wide.
// - Enabled open-wire sensed raises point fault.
// - Unlatched open-wire fault clears when condition goes.
// - Per-point open-wire checking disable.
// - Enabled short sensed flags fault, clears unless latched.
// - Latched alarms hold until explicit reset.
// - Input latched alarm cleared only by reset message.
// - Separate active, short, open-wire thresholds.
// - Output produces on consume, diagnostic change, interval.
// - Output change-of-state production always on.
// - No-load fault only while commanded off.
// - Per-point no-load checking disable.
// - Output short or over-current flags point fault.
// - Short fault cleared by off, service, tag bit.
// - Output latch cleared by message or tag reset.
// - Report simplex/duplex and both modules' status.
// - Report link, duplex, speed, autoneg per port.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dio_diag
   import dio_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire dio_pkg::dio_addr_t addr_i,
   input wire dio_pkg::dio_data_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic [`DIO_IN_PTS*`DIO_THR_W-1:0] in_level_i,
   input wire logic [`DIO_OUT_PTS-1:0] out_short_i,
   input wire logic [`DIO_OUT_PTS-1:0] out_noload_i,
   input wire logic [1:0] partner_ok_i,
   input wire logic [`DIO_PORTS-1:0] port_link_i,
   input wire logic [`DIO_PORTS-1:0] port_fdx_i,
   input wire logic [`DIO_PORTS-1:0] port_speed_i,
   input wire logic [`DIO_PORTS-1:0] port_aneg_i,
   output logic [`DIO_OUT_PTS-1:0] out_drive_o,
   output logic in_prod_o,
   output logic out_prod_o,
   output logic irq_o
);
   import dio_pkg::*;

   typedef struct packed {
      logic [1:0] warm;
      dio_out_t s_sh0;
      dio_out_t s_sh1;
      dio_out_t s_nl0;
      dio_out_t s_nl1;
      logic [1:0] s_ok0;
      logic [1:0] s_ok1;
      logic [4*`DIO_PORTS-1:0] s_net0;
      logic [4*`DIO_PORTS-1:0] s_net1;
      dio_in_t ow_en;
      dio_in_t sc_en;
      dio_in_t cos_mask;
      logic [3:0] ctrl;
      dio_thr_t thr_act;
      dio_thr_t thr_sc;
      dio_thr_t thr_ow;
      dio_out_t nl_en;
      dio_out_t out_data;
      logic [15:0] rpi;
      dio_in_t in_val;
      dio_in_t in_ow;
      dio_in_t in_sc;
      dio_out_t out_sc;
      dio_out_t out_nl;
      logic [15:0] tick_cnt;
      logic [15:0] rpi_cnt;
      logic out_consumed;
      logic [`DIO_IRQ_W-1:0] irq_stat;
      logic [`DIO_IRQ_W-1:0] irq_mask;
      logic [31:0] rdata;
      dio_out_t drive;
      logic in_prod;
      logic out_prod;
      logic irq;
   } dio_state_s;

   dio_state_s st_r;
   dio_state_s st_nxt;

   // Level classification: at or above the short threshold is a short, below the open threshold an open wire.
   function automatic logic [2:0] classify(input dio_thr_t lvl, input dio_thr_t t_act,
                                           input dio_thr_t t_sc, input dio_thr_t t_ow);
      classify = {lvl >= t_sc, lvl < t_ow, lvl >= t_act};
   endfunction : classify

   // Latched alarm: live condition always sets, clear only drops a bit with no live cause.
   function automatic logic [15:0] alarm(input logic [15:0] cur, input logic [15:0] live,
                                         input logic latch, input logic clr);
      if (!latch) begin
         alarm = live;
      end else if (clr) begin
         alarm = live;
      end else begin
         alarm = cur | live;
      end
   endfunction : alarm

   genvar gi;

   logic [`DIO_IN_PTS*`DIO_THR_W-1:0] lvl_s0_r;
   logic [`DIO_IN_PTS*`DIO_THR_W-1:0] lvl_s1_r;
   dio_in_t act_s;
   dio_in_t ow_s;
   dio_in_t sc_s;

   // Analog levels are synchronised as a bus; a level is classified only after two flops.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         lvl_s0_r <= '0;
         lvl_s1_r <= '0;
      end else begin
         lvl_s0_r <= in_level_i;
         lvl_s1_r <= lvl_s0_r;
      end
   end

   generate
      for (gi = 0; gi < `DIO_IN_PTS; gi++) begin : g_cls_s
         assign {sc_s[gi], ow_s[gi], act_s[gi]} =
            classify(lvl_s1_r[gi*`DIO_THR_W +: `DIO_THR_W], st_r.thr_act, st_r.thr_sc, st_r.thr_ow);
      end
   endgenerate

   always_comb begin
      logic wr_cmd;
      logic in_clr;
      logic out_lclr;
      logic sc_clr;
      logic tick;
      logic rpi_hit;
      logic diag_chg_in;
      logic diag_chg_out;
      logic primed;
      dio_in_t ow_live;
      dio_in_t sc_live;
      dio_out_t osc_live;
      dio_out_t onl_live;
      dio_in_t ow_n;
      dio_in_t sc_n;
      dio_out_t osc_n;
      dio_out_t onl_n;
      logic [`DIO_IRQ_W-1:0] ev;
      wr_cmd = 1'b0;
      in_clr = 1'b0;
      out_lclr = 1'b0;
      sc_clr = 1'b0;
      tick = 1'b0;
      rpi_hit = 1'b0;
      diag_chg_in = 1'b0;
      diag_chg_out = 1'b0;
      primed = 1'b0;
      ow_live = '0;
      sc_live = '0;
      osc_live = '0;
      onl_live = '0;
      ow_n = '0;
      sc_n = '0;
      osc_n = '0;
      onl_n = '0;
      ev = '0;
      st_nxt = st_r;
      st_nxt.out_consumed = 1'b0;

      // Pin synchronisers.
      st_nxt.s_sh0 = out_short_i;
      st_nxt.s_sh1 = st_r.s_sh0;
      st_nxt.s_nl0 = out_noload_i;
      st_nxt.s_nl1 = st_r.s_nl0;
      st_nxt.s_ok0 = partner_ok_i;
      st_nxt.s_ok1 = st_r.s_ok0;
      st_nxt.s_net0 = {port_aneg_i, port_speed_i, port_fdx_i, port_link_i};
      st_nxt.s_net1 = st_r.s_net0;
      // The level synchroniser holds zeros after reset, which would read as open wires on every point.
      // Input diagnostics wait until both flops carry real levels, so no false fault follows reset.
      st_nxt.warm = (st_r.warm == 2'h2) ? 2'h2 : st_r.warm + 2'h1;
      primed = (st_r.warm == 2'h2);

      // Register writes.
      if (wr_i) begin
         unique case (addr_i)
            `DIO_A_IN_OW_EN: st_nxt.ow_en = wdata_i[15:0];
            `DIO_A_IN_SC_EN: st_nxt.sc_en = wdata_i[15:0];
            `DIO_A_IN_COS_MASK: st_nxt.cos_mask = wdata_i[15:0];
            `DIO_A_CTRL: st_nxt.ctrl = wdata_i[3:0];
            `DIO_A_IN_THR: begin
               st_nxt.thr_act = wdata_i[7:0];
               st_nxt.thr_sc = wdata_i[15:8];
               st_nxt.thr_ow = wdata_i[23:16];
            end
            `DIO_A_OUT_NL_EN: st_nxt.nl_en = wdata_i[7:0];
            `DIO_A_OUT_DATA: begin
               st_nxt.out_data = wdata_i[7:0];
               st_nxt.out_consumed = 1'b1;
            end
            `DIO_A_RPI: st_nxt.rpi = wdata_i[15:0];
            `DIO_A_CMD: wr_cmd = 1'b1;
            `DIO_A_IRQ_MASK: st_nxt.irq_mask = wdata_i[`DIO_IRQ_W-1:0];
            default: ;
         endcase
      end
      in_clr = wr_cmd && wdata_i[`DIO_CMD_IN_RESET];
      out_lclr = wr_cmd && (wdata_i[`DIO_CMD_OUT_RESET] || wdata_i[`DIO_CMD_TAG_RESET]);
      sc_clr = wr_cmd && (wdata_i[`DIO_CMD_SHORT_RESET] || wdata_i[`DIO_CMD_TAG_RESET]);

      // Input diagnostics.
      ow_live = primed ? (ow_s & st_r.ow_en) : '0;
      sc_live = primed ? (sc_s & st_r.sc_en) : '0;
      ow_n = alarm(st_r.in_ow, ow_live, st_r.ctrl[`DIO_CTRL_IN_LATCH], in_clr);
      sc_n = alarm(st_r.in_sc, sc_live, st_r.ctrl[`DIO_CTRL_IN_LATCH], in_clr);
      st_nxt.in_ow = ow_n;
      st_nxt.in_sc = sc_n;
      st_nxt.in_val = primed ? (act_s & ~sc_s & ~ow_s) : st_r.in_val;
      diag_chg_in = (ow_n != st_r.in_ow) || (sc_n != st_r.in_sc);
      st_nxt.in_prod = (|((st_nxt.in_val ^ st_r.in_val) & st_r.cos_mask)) ||
                       (diag_chg_in && st_r.ctrl[`DIO_CTRL_DIAG_COS]);

      // Output diagnostics.
      osc_live = st_r.s_sh1;
      onl_live = st_r.s_nl1 & ~st_r.out_data & st_r.nl_en;
      osc_n = 8'(alarm({8'h00, st_r.out_sc}, {8'h00, osc_live}, 1'b1, sc_clr)
              & {8'h00, st_r.out_data} | {8'h00, osc_live});
      onl_n = 8'(alarm({8'h00, st_r.out_nl}, {8'h00, onl_live}, st_r.ctrl[`DIO_CTRL_OUT_LATCH], out_lclr)
              & {8'h00, st_r.nl_en});
      st_nxt.out_sc = osc_n;
      st_nxt.out_nl = onl_n;
      diag_chg_out = (osc_n != st_r.out_sc) || (onl_n != st_r.out_nl);
      // A shorted point is switched off so the fault cannot be cleared while current still flows.
      st_nxt.drive = st_r.out_data & ~osc_n;

      // Packet interval timer in 1 ms ticks.
      if (st_r.tick_cnt == 16'(`DIO_TICK_CYC - 1)) begin
         st_nxt.tick_cnt = '0;
         tick = 1'b1;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
      end
      rpi_hit = tick && (st_r.rpi_cnt + 16'h0001 >= st_r.rpi) && (st_r.rpi != 16'h0000);
      st_nxt.out_prod = st_r.out_consumed || diag_chg_out || rpi_hit;
      if (st_nxt.out_prod) begin
         st_nxt.rpi_cnt = '0;
      end else if (tick) begin
         st_nxt.rpi_cnt = st_r.rpi_cnt + 16'h0001;
      end

      // Interrupt status: a read clears, but a same-cycle event wins.
      ev[`DIO_IRQ_IN_PROD] = st_nxt.in_prod;
      ev[`DIO_IRQ_OUT_PROD] = st_nxt.out_prod;
      ev[`DIO_IRQ_IN_FAULT] = |(ow_n | sc_n);
      ev[`DIO_IRQ_OUT_FAULT] = |(osc_n | onl_n);
      if (rd_i && addr_i == `DIO_A_IRQ_STAT) begin
         st_nxt.irq_stat = ev;
      end else begin
         st_nxt.irq_stat = st_r.irq_stat | ev;
      end
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

      // Read data.
      st_nxt.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            `DIO_A_IN_OW_EN: st_nxt.rdata = {16'h0000, st_r.ow_en};
            `DIO_A_IN_SC_EN: st_nxt.rdata = {16'h0000, st_r.sc_en};
            `DIO_A_IN_COS_MASK: st_nxt.rdata = {16'h0000, st_r.cos_mask};
            `DIO_A_CTRL: st_nxt.rdata = {28'h0000000, st_r.ctrl};
            `DIO_A_IN_THR: st_nxt.rdata = {8'h00, st_r.thr_ow, st_r.thr_sc, st_r.thr_act};
            `DIO_A_OUT_NL_EN: st_nxt.rdata = {24'h000000, st_r.nl_en};
            `DIO_A_OUT_DATA: st_nxt.rdata = {24'h000000, st_r.out_data};
            `DIO_A_RPI: st_nxt.rdata = {16'h0000, st_r.rpi};
            `DIO_A_IN_STAT: st_nxt.rdata = {16'h0000, st_r.in_val};
            `DIO_A_IN_FAULT: st_nxt.rdata = {st_r.in_sc, st_r.in_ow};
            `DIO_A_OUT_FAULT: st_nxt.rdata = {8'h00, st_r.drive, st_r.out_nl, st_r.out_sc};
            `DIO_A_RED_STAT: st_nxt.rdata = {29'h00000000, st_r.s_ok1, st_r.ctrl[`DIO_CTRL_DUPLEX]};
            `DIO_A_LINK_STAT: st_nxt.rdata = {24'h000000, st_r.s_net1};
            `DIO_A_IRQ_STAT: st_nxt.rdata = {28'h0000000, st_r.irq_stat};
            `DIO_A_IRQ_MASK: st_nxt.rdata = {28'h0000000, st_r.irq_mask};
            default: st_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.ow_en <= 16'hffff;
         st_r.sc_en <= 16'hffff;
         st_r.cos_mask <= 16'hffff;
         st_r.nl_en <= 8'hff;
         st_r.thr_act <= `DIO_THR_ACT_RST;
         st_r.thr_sc <= `DIO_THR_SC_RST;
         st_r.thr_ow <= `DIO_THR_OW_RST;
         st_r.rpi <= `DIO_RPI_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o = st_r.rdata;
   assign out_drive_o = st_r.drive;
   assign in_prod_o = st_r.in_prod;
   assign out_prod_o = st_r.out_prod;
   assign irq_o = st_r.irq;
endmodule : dio_diag
`default_nettype wire

// ---- dio_field.sv ----
// Field wiring model that holds one sensed level per input point.
`timescale 1ns/1ps
`default_nettype none
module dio_field (
   input wire logic clock_i,
   input wire logic set_i,
   input wire logic [3:0] idx_i,
   input wire logic [7:0] lvl_i,
   output logic [127:0] level_o
);
   // Every point starts at a healthy end-of-line level, so no fault shows before a scenario asks for one.
   logic [7:0] lvl_r [16] = '{default: 8'h90};
   always_ff @(posedge clock_i) begin
      if (set_i) begin
         lvl_r[idx_i] <= lvl_i;
      end
   end
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         level_o[i*8 +: 8] = lvl_r[i];
      end
   end
endmodule : dio_field
`default_nettype wire

// ---- dio_diag_monitor.sv ----
// Port checker for the discrete diagnostics block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "dio_cfg.svh"
module dio_diag_monitor (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire dio_pkg::dio_addr_t addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [127:0] in_level_i,
   input wire logic [7:0] out_short_i,
   input wire logic [1:0] partner_ok_i,
   input wire logic [1:0] port_link_i,
   input wire logic [1:0] port_fdx_i,
   input wire logic [1:0] port_speed_i,
   input wire logic [1:0] port_aneg_i,
   input wire logic [7:0] out_drive_o,
   input wire logic in_prod_o,
   input wire logic out_prod_o,
   input wire logic irq_o
);
   import dio_pkg::*;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   AST_RESET_QUIET: assert property ($past(rst_i) |-> rdata_o == 32'h0 && out_drive_o == 8'h0 && !irq_o)
      else $error("outputs not quiet after reset");
   AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read answer");
   AST_UNMAPPED: assert property (rd_i && addr_i > 5'h0f |=> rdata_o == 32'h0)
      else $error("unmapped read returned data");
   AST_WRITE_PROD: assert property (wr_i && addr_i == `DIO_A_OUT_DATA |-> ##2 out_prod_o)
      else $error("no output production after output data write");
   AST_SHORT_OFF: assert property ($stable(out_short_i) [*6] |-> (out_drive_o & out_short_i) == 8'h0)
      else $error("shorted output point still driven");
   AST_IN_QUIET: assert property (($stable(in_level_i) && !wr_i) [*8] |=> !in_prod_o)
      else $error("input production without any change");
   AST_PAIR_STAT: assert property ($stable(partner_ok_i) [*4] ##0 (rd_i && addr_i == `DIO_A_RED_STAT)
      |=> rdata_o[2:1] == $past(partner_ok_i)) else $error("pair status read wrong");
   AST_LINK_STAT: assert property ($stable({port_aneg_i, port_speed_i, port_fdx_i, port_link_i}) [*4]
      ##0 (rd_i && addr_i == `DIO_A_LINK_STAT)
      |=> rdata_o[7:0] == $past({port_aneg_i, port_speed_i, port_fdx_i, port_link_i}))
      else $error("link status read wrong");
endmodule : dio_diag_monitor
bind dio_diag dio_diag_monitor u_mon (.clock_i, .rst_i, .addr_i, .wr_i, .rd_i, .rdata_o, .in_level_i, .out_short_i,
   .partner_ok_i, .port_link_i, .port_fdx_i, .port_speed_i, .port_aneg_i, .out_drive_o, .in_prod_o, .out_prod_o, .irq_o);
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the discrete diagnostics block.
`timescale 1ns/1ps
`default_nettype none
`include "dio_cfg.svh"
module tb_top;
   import dio_pkg::*;
   localparam dio_addr_t a_if = `DIO_A_IN_FAULT;
   localparam dio_addr_t a_of = `DIO_A_OUT_FAULT;
   localparam logic [31:0] all_m = 32'hffff_ffff;
   logic clock_i = 1'h0;
   logic rst_i = 1'h1;
   dio_addr_t addr = 5'h00;
   dio_data_t wdata = 32'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata;
   logic [127:0] level;
   logic [7:0] osh = 8'h00;
   logic [7:0] onl = 8'h00;
   logic [1:0] pok = 2'h3;
   logic [7:0] pst = 8'h00;
   logic [7:0] drive;
   logic iprod;
   logic oprod;
   logic irq;
   logic lset = 1'h0;
   logic [3:0] lidx = 4'h0;
   logic [7:0] lval = 8'h00;
   int fail_count = 0;
   int checks_done = 0;
   int ip_n = 0;
   int op_n = 0;
   int n0;
   int m0;
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   // Production pulses are counted so that a scenario can ask how many happened, not just whether one did.
   always @(posedge clock_i) begin
      if (iprod === 1'h1) ip_n++;
      if (oprod === 1'h1) op_n++;
   end
   dio_field u_field (.clock_i(clock_i), .set_i(lset), .idx_i(lidx), .lvl_i(lval), .level_o(level));
   dio_diag u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .in_level_i(level), .out_short_i(osh), .out_noload_i(onl), .partner_ok_i(pok),
      .port_link_i(pst[1:0]), .port_fdx_i(pst[3:2]), .port_speed_i(pst[5:4]), .port_aneg_i(pst[7:6]),
      .out_drive_o(drive), .in_prod_o(iprod), .out_prod_o(oprod), .irq_o(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input dio_addr_t a, input dio_data_t d);
      @(posedge clock_i);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clock_i);
      wr <= 1'h0;
   endtask : wr_reg
   task automatic rd_chk(input dio_addr_t a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clock_i);
      rd <= 1'h1;
      addr <= a;
      @(posedge clock_i);
      rd <= 1'h0;
      #1;
      chk(rdata & m, e);
   endtask : rd_chk
   task automatic settle;
      repeat (8) @(posedge clock_i);
   endtask : settle
   task automatic set_lvl(input logic [3:0] i, input logic [7:0] v);
      settle();
      n0 = ip_n;
      @(posedge clock_i);
      lset <= 1'h1;
      lidx <= i;
      lval <= v;
      @(posedge clock_i);
      lset <= 1'h0;
      settle();
   endtask : set_lvl
   task automatic set_pins(input logic [7:0] s, input logic [7:0] n);
      settle();
      m0 = op_n;
      osh <= s;
      onl <= n;
      settle();
   endtask : set_pins
   task automatic t_input;
      rd_chk(`DIO_A_IN_THR, all_m, 32'h0010_e080);
      rd_chk(5'h1f, all_m, 32'h0);
      wr_reg(`DIO_A_IRQ_MASK, 32'h4);
      set_lvl(4'h3, 8'h00);
      rd_chk(a_if, all_m, 32'h8);
      chk(irq, 32'h1);
      set_lvl(4'h3, 8'h90);
      rd_chk(a_if, all_m, 32'h0);
      rd_chk(`DIO_A_IRQ_STAT, 32'h4, 32'h4);
      settle();
      chk(irq, 32'h0);
      wr_reg(`DIO_A_IN_OW_EN, 32'hfff7);
      set_lvl(4'h3, 8'h00);
      rd_chk(a_if, all_m, 32'h0);
      wr_reg(`DIO_A_IRQ_MASK, 32'h0);
      set_lvl(4'h5, 8'hf0);
      rd_chk(a_if, all_m, 32'h0020_0000);
      chk(irq, 32'h0);
      set_lvl(4'h5, 8'h90);
      rd_chk(a_if, all_m, 32'h0);
      wr_reg(`DIO_A_CTRL, 32'h1);
      set_lvl(4'h5, 8'hf0);
      set_lvl(4'h5, 8'h90);
      rd_chk(a_if, all_m, 32'h0020_0000);
      wr_reg(`DIO_A_CMD, 32'ha);
      rd_chk(a_if, all_m, 32'h0020_0000);
      set_lvl(4'h5, 8'hf0);
      wr_reg(`DIO_A_CMD, 32'h1);
      rd_chk(a_if, all_m, 32'h0020_0000);
      set_lvl(4'h5, 8'h90);
      wr_reg(`DIO_A_CMD, 32'h1);
      rd_chk(a_if, all_m, 32'h0);
      wr_reg(`DIO_A_CTRL, 32'h0);
      wr_reg(`DIO_A_IN_THR, 32'h0040_a080);
      set_lvl(4'h7, 8'h9f);
      rd_chk(`DIO_A_IN_STAT, 32'h80, 32'h80);
      set_lvl(4'h7, 8'ha0);
      rd_chk(a_if, 32'h0080_0080, 32'h0080_0000);
      set_lvl(4'h7, 8'h3f);
      rd_chk(a_if, 32'h0080_0080, 32'h80);
      wr_reg(`DIO_A_IN_THR, 32'h0010_e080);
      set_lvl(4'h7, 8'h90);
   endtask : t_input
   task automatic t_cos;
      wr_reg(`DIO_A_IN_COS_MASK, 32'hfdff);
      set_lvl(4'h9, 8'h50);
      chk(ip_n - n0, 32'h0);
      wr_reg(`DIO_A_CTRL, 32'h4);
      set_lvl(4'h9, 8'h00);
      chk(ip_n - n0, 32'h1);
      wr_reg(`DIO_A_CTRL, 32'h0);
      wr_reg(`DIO_A_IN_COS_MASK, 32'hffff);
      set_lvl(4'h9, 8'h90);
      chk(ip_n - n0, 32'h1);
   endtask : t_cos
   task automatic t_output;
      wr_reg(`DIO_A_OUT_DATA, 32'h0f);
      set_pins(8'h00, 8'h42);
      rd_chk(a_of, all_m, 32'h000f_4000);
      chk(op_n - m0, 32'h1);
      wr_reg(`DIO_A_OUT_NL_EN, 32'hbf);
      rd_chk(a_of, all_m, 32'h000f_0000);
      wr_reg(`DIO_A_OUT_NL_EN, 32'hff);
      set_pins(8'h04, 8'h00);
      chk(drive, 32'h0b);
      set_pins(8'h00, 8'h00);
      rd_chk(a_of, all_m, 32'h000b_0004);
      wr_reg(`DIO_A_OUT_DATA, 32'h0b);
      rd_chk(a_of, all_m, 32'h000b_0000);
      for (int c = 2; c < 4; c++) begin
         wr_reg(`DIO_A_OUT_DATA, 32'h0f);
         set_pins(8'h04, 8'h00);
         set_pins(8'h00, 8'h00);
         wr_reg(`DIO_A_CMD, 32'h1 << c);
         rd_chk(a_of, all_m, 32'h000f_0000);
         wr_reg(`DIO_A_CTRL, 32'h2);
         set_pins(8'h00, 8'h10);
         set_pins(8'h00, 8'h00);
         rd_chk(a_of, all_m, 32'h000f_1000);
         wr_reg(`DIO_A_CMD, (c == 2) ? 32'h2 : 32'h8);
         rd_chk(a_of, all_m, 32'h000f_0000);
         wr_reg(`DIO_A_CTRL, 32'h0);
      end
      pok <= 2'h1;
      pst <= 8'hb4;
      wr_reg(`DIO_A_CTRL, 32'h8);
      settle();
      rd_chk(`DIO_A_RED_STAT, all_m, 32'h3);
      rd_chk(`DIO_A_LINK_STAT, all_m, 32'hb4);
      wr_reg(`DIO_A_RPI, 32'h1);
      m0 = op_n;
      repeat (40100) @(posedge clock_i);
      chk(op_n > m0, 32'h1);
      wr_reg(`DIO_A_RPI, 32'h0);
   endtask : t_output
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (2) @(posedge clock_i);
      rst_i <= 1'h0;
      t_input();
      t_cos();
      t_output();
      conclude();
   end
   // The interval scenario alone needs about 40000 cycles, so the limit leaves ample margin above that.
   initial begin
      #(25 * 90000);
      fail_count++;
      conclude();
   end
endmodule : tb_top
`default_nettype wire
